// [rtl/brk_consts.svh]
/*
 Register offsets, field positions, reset values and bit counts of the
 break generator. Assumes inclusion by bare name from rtl/.
*/
`ifndef BRK_CONSTS_SVH
`define BRK_CONSTS_SVH
`define OFF_CTRL_ONE 3'h0
`define OFF_CTRL_TWO 3'h1
`define OFF_CTRL_THREE 3'h2
`define OFF_BAUD_DIV 3'h3
`define OFF_TX_DATA 3'h4
`define OFF_STATUS 3'h5
`define BIT_WORD_LONG 0
`define BIT_TE 0
`define BIT_SBK 1
`define BIT_LIN_EN 0
`define RST_BAUD_DIV 16'h0001
`define BITS_SHORT 4'hA
`define BITS_LONG 4'hB
`define BITS_LIN 4'hD
`define LIN_SYNCH_BITS 4'hA
`define LIN_HEADER_MAX 6'h31
`endif

// [rtl/brk_pkg.sv]
/*
 Types shared by the break generator: transmitter states and the
 packed control word. Assumes nothing of its surroundings.
*/
package brk_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_IDLE_LINE = 2'b01,
        ST_BREAK = 2'b10,
        ST_CHAR = 2'b11
    } tx_state_t;
    typedef struct packed {
        logic word_long;
        logic lin_en;
        logic te;
        logic send_break_request;
    } ctrl_t;
endpackage

// [rtl/sci_break_generator.sv]
/*
 Serial transmitter with break, idle-line and character generation and a
 LIN master break length. Assumes a simple register port master that
 keeps strobes one cycle long, and a single 200 MHz clock.
*/
// Summary of operation
// R01: Word length short, LIN enable clear: each break holds the line low exactly 10 bit times.
// R02: Word length long: each break holds the line low exactly 11 bit times.
// R03: Software requests one break by writing the break bit one, then zero.
// R04: While the break bit stays set, breaks follow one another.
// R05: LIN master when LIN enable set and word length short.
// R06: LIN master break holds the line low for 13 bit times.
// R07: Toggling transmitter enable queues an idle line sent before a following break.
// R08: Software masks interrupts around the enable toggle and break request.
// R09: LIN break at least 13 bits; break plus synch within 49 bits.
// R10: Break length exact at any divisor; one request never gives two breaks.
// R11: With nothing to send, the output rests at the mark level.
`timescale 1ns/100ps
`include "brk_consts.svh"
module sci_break_generator #(
    parameter int DIV_W = 16
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic [2:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    output logic tx_out
);
    import brk_pkg::*;

    function automatic logic hit(input logic stb, input logic [2:0] a,
                                 input logic [2:0] off);
        hit = stb && (a == off);
    endfunction

    ctrl_t ctrl_r, ctrl_nxt;
    logic [DIV_W-1:0] div_r, div_nxt;
    logic [8:0] data_r, data_nxt;
    logic data_full_r, data_full_nxt;
    logic brk_pend_r, brk_pend_nxt;
    logic idle_pend_r, idle_pend_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    tx_state_t state_r, state_nxt;
    logic [DIV_W-1:0] baud_cnt_r, baud_cnt_nxt;
    logic [DIV_W-1:0] cur_div_r, cur_div_nxt;
    logic [3:0] bits_left_r, bits_left_nxt;
    logic [3:0] brk_bits_r, brk_bits_nxt;
    logic [10:0] shift_r, shift_nxt;
    logic tx_r, tx_nxt;
    logic sbk_rise, te_rise, lin_master, bit_end, sym_done, pick, start_brk;
    logic [3:0] brk_len, frame_len;

    assign lin_master = ctrl_r.lin_en && !ctrl_r.word_long; // [R05]
    assign brk_len = lin_master ? `BITS_LIN
                   : (ctrl_r.word_long ? `BITS_LONG : `BITS_SHORT); // [R01] [R02] [R06]
    assign frame_len = ctrl_r.word_long ? `BITS_LONG : `BITS_SHORT;
    assign sbk_rise = hit(wr_in, addr_in, `OFF_CTRL_TWO) && wdata_in[`BIT_SBK]
                      && !ctrl_r.send_break_request;
    assign te_rise = hit(wr_in, addr_in, `OFF_CTRL_TWO) && wdata_in[`BIT_TE]
                     && !ctrl_r.te;
    assign bit_end = (state_r != ST_IDLE) && (baud_cnt_r == cur_div_r - 1'b1);
    assign sym_done = bit_end && (bits_left_r == 4'h1);
    assign pick = (state_r == ST_IDLE) || sym_done;
    // Idle line outranks a break so the queued idle always goes first
    assign start_brk = pick && ctrl_r.te && !idle_pend_r
                       && (brk_pend_r || ctrl_r.send_break_request); // [R04] [R07]

    // Register group
    always_comb begin
        ctrl_nxt = ctrl_r;
        div_nxt = div_r;
        data_nxt = data_r;
        data_full_nxt = data_full_r;
        brk_pend_nxt = brk_pend_r;
        idle_pend_nxt = idle_pend_r;
        rdata_nxt = 16'h0000;
        if (hit(wr_in, addr_in, `OFF_CTRL_ONE)) begin
            ctrl_nxt.word_long = wdata_in[`BIT_WORD_LONG];
        end else if (hit(wr_in, addr_in, `OFF_CTRL_TWO)) begin
            ctrl_nxt.te = wdata_in[`BIT_TE];
            ctrl_nxt.send_break_request = wdata_in[`BIT_SBK];
        end else if (hit(wr_in, addr_in, `OFF_CTRL_THREE)) begin
            ctrl_nxt.lin_en = wdata_in[`BIT_LIN_EN];
        end else if (hit(wr_in, addr_in, `OFF_BAUD_DIV)) begin
            div_nxt = wdata_in[DIV_W-1:0];
        end
        // Transmitter off drops a queued break and idle line; a queued character stays
        if (!ctrl_r.te) begin
            brk_pend_nxt = 1'b0;
            idle_pend_nxt = 1'b0;
        end
        // A pending request is consumed once, so set-then-clear gives one break
        if (start_brk) begin
            brk_pend_nxt = 1'b0; // [R10]
        end
        if (pick && ctrl_r.te && idle_pend_r) begin
            idle_pend_nxt = 1'b0;
        end
        if (pick && ctrl_r.te && !idle_pend_r && !brk_pend_r && !ctrl_r.send_break_request
            && data_full_r) begin
            data_full_nxt = 1'b0;
        end
        // Set wins over the same-cycle clear
        if (sbk_rise) begin
            brk_pend_nxt = 1'b1; // [R03]
        end
        if (te_rise) begin
            idle_pend_nxt = 1'b1; // [R07]
        end
        // A write while full is refused; software polls the empty flag
        if (hit(wr_in, addr_in, `OFF_TX_DATA) && !data_full_r) begin
            data_nxt = wdata_in[8:0];
            data_full_nxt = 1'b1;
        end
        if (rd_in) begin
            if (addr_in == `OFF_CTRL_ONE) begin
                rdata_nxt[`BIT_WORD_LONG] = ctrl_r.word_long;
            end else if (addr_in == `OFF_CTRL_TWO) begin
                rdata_nxt[`BIT_TE] = ctrl_r.te;
                rdata_nxt[`BIT_SBK] = ctrl_r.send_break_request;
            end else if (addr_in == `OFF_CTRL_THREE) begin
                rdata_nxt[`BIT_LIN_EN] = ctrl_r.lin_en;
            end else if (addr_in == `OFF_BAUD_DIV) begin
                rdata_nxt[DIV_W-1:0] = div_r;
            end else if (addr_in == `OFF_TX_DATA) begin
                rdata_nxt[8:0] = data_r;
            end else if (addr_in == `OFF_STATUS) begin
                rdata_nxt[5:0] = {idle_pend_r, brk_pend_r, state_r,
                                  state_r != ST_IDLE, !data_full_r};
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ctrl_r <= '0;
            div_r <= `RST_BAUD_DIV;
            data_r <= 9'h000;
            data_full_r <= 1'b0;
            brk_pend_r <= 1'b0;
            idle_pend_r <= 1'b0;
            rdata_r <= 16'h0000;
        end else if (clk_en_in) begin
            ctrl_r <= ctrl_nxt;
            div_r <= div_nxt;
            data_r <= data_nxt;
            data_full_r <= data_full_nxt;
            brk_pend_r <= brk_pend_nxt;
            idle_pend_r <= idle_pend_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Transmitter group
    always_comb begin
        state_nxt = state_r;
        baud_cnt_nxt = baud_cnt_r;
        cur_div_nxt = cur_div_r;
        bits_left_nxt = bits_left_r;
        brk_bits_nxt = brk_bits_r;
        shift_nxt = shift_r;
        if (state_r != ST_IDLE) begin
            baud_cnt_nxt = bit_end ? '0 : baud_cnt_r + 1'b1;
            if (bit_end) begin
                bits_left_nxt = bits_left_r - 4'h1;
                shift_nxt = {1'b1, shift_r[10:1]};
            end
        end
        if (pick) begin
            // Divisor latched per symbol and counter restarted: exact length
            cur_div_nxt = (div_r == '0) ? {{(DIV_W-1){1'b0}}, 1'b1} : div_r; // [R10]
            baud_cnt_nxt = '0;
            shift_nxt = 11'h7FF;
            if (!ctrl_r.te) begin
                state_nxt = ST_IDLE;
            end else if (idle_pend_r) begin
                state_nxt = ST_IDLE_LINE; // [R07]
                bits_left_nxt = frame_len;
            end else if (brk_pend_r || ctrl_r.send_break_request) begin
                state_nxt = ST_BREAK; // [R04]
                bits_left_nxt = brk_len; // [R09]
                brk_bits_nxt = brk_len;
            end else if (data_full_r) begin
                state_nxt = ST_CHAR;
                bits_left_nxt = frame_len;
                shift_nxt = {1'b1, ctrl_r.word_long ? data_r[8] : 1'b1,
                             data_r[7:0], 1'b0};
            end else begin
                state_nxt = ST_IDLE;
            end
        end
        case (state_nxt)
            ST_BREAK: tx_nxt = 1'b0;
            ST_CHAR: tx_nxt = shift_nxt[0];
            default: tx_nxt = 1'b1; // [R11]
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_r <= ST_IDLE;
            baud_cnt_r <= '0;
            cur_div_r <= `RST_BAUD_DIV;
            bits_left_r <= 4'h0;
            brk_bits_r <= 4'h0;
            shift_r <= 11'h7FF;
            tx_r <= 1'b1;
        end else if (clk_en_in) begin
            state_r <= state_nxt;
            baud_cnt_r <= baud_cnt_nxt;
            cur_div_r <= cur_div_nxt;
            bits_left_r <= bits_left_nxt;
            brk_bits_r <= brk_bits_nxt;
            shift_r <= shift_nxt;
            tx_r <= tx_nxt;
        end
    end

    assign tx_out = tx_r;
    assign rdata_out = rdata_r;

    // Checking helpers: cycles spent in the current break
    int brk_cyc_r;
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            brk_cyc_r <= 0;
        end else if (clk_en_in) begin
            brk_cyc_r <= start_brk ? 0 : brk_cyc_r + 1;
        end
    end
    int brk_need;
    assign brk_need = int'(brk_bits_r) * int'(cur_div_r);

    // Checking helpers: idle line cycles and due length, latched at its start
    int idle_cyc_r;
    int idle_need_r;
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            idle_cyc_r <= 0;
            idle_need_r <= 0;
        end else if (clk_en_in) begin
            idle_cyc_r <= (pick && state_nxt == ST_IDLE_LINE) ? 0 : idle_cyc_r + 1;
            if (pick && state_nxt == ST_IDLE_LINE) begin
                idle_need_r <= int'(frame_len) * int'(cur_div_nxt);
            end
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    brk_short_len_a: assert property (clk_en_in && state_r == ST_BREAK && sym_done // [R01]
        && brk_bits_r == `BITS_SHORT |-> brk_cyc_r + 1 == 10 * int'(cur_div_r))
        else $error("short break length wrong");
    brk_long_len_a: assert property (clk_en_in && state_r == ST_BREAK && sym_done // [R02]
        && brk_bits_r == `BITS_LONG |-> brk_cyc_r + 1 == 11 * int'(cur_div_r))
        else $error("long break length wrong");
    brk_repeat_a: assert property (clk_en_in && state_r == ST_BREAK && sym_done // [R04]
        && ctrl_r.send_break_request && ctrl_r.te && !idle_pend_r |=> state_r == ST_BREAK && !tx_out)
        else $error("held break bit did not repeat break");
    lin_select_a: assert property (clk_en_in && start_brk && ctrl_r.lin_en // [R05]
        && !ctrl_r.word_long |=> brk_bits_r == `BITS_LIN)
        else $error("LIN master mode not selected");
    lin_len_a: assert property (clk_en_in && state_r == ST_BREAK && sym_done // [R06]
        && brk_bits_r == `BITS_LIN |-> brk_cyc_r + 1 == 13 * int'(cur_div_r))
        else $error("LIN break length wrong");
    idle_first_a: assert property (clk_en_in && state_r == ST_IDLE_LINE && sym_done // [R07]
        && ctrl_r.te && !idle_pend_r && (brk_pend_r || ctrl_r.send_break_request) |=> state_r == ST_BREAK)
        else $error("break did not follow idle line");
    idle_mark_a: assert property (state_r == ST_IDLE_LINE |-> tx_out) // [R07]
        else $error("idle line not at mark");
    lin_header_a: assert property (clk_en_in && start_brk && lin_master // [R09]
        |=> brk_bits_r >= 4'hD && brk_bits_r + `LIN_SYNCH_BITS <= `LIN_HEADER_MAX)
        else $error("LIN header budget broken");
    single_brk_a: assert property (clk_en_in && state_r == ST_BREAK && sym_done // [R10]
        && !ctrl_r.send_break_request && !brk_pend_r |=> state_r != ST_BREAK)
        else $error("second break without request");
    exact_len_a: assert property (clk_en_in && state_r == ST_BREAK && sym_done // [R10]
        |-> brk_cyc_r + 1 == brk_need)
        else $error("break length not exact");
    rest_mark_a: assert property (state_r == ST_IDLE && $past(state_r) == ST_IDLE // [R11]
        |-> tx_out)
        else $error("line not at mark when idle");
    idle_len_a: assert property (clk_en_in && state_r == ST_IDLE_LINE && sym_done // [R07]
        |-> idle_cyc_r + 1 == idle_need_r)
        else $error("idle line length wrong");
    break_low_a: assert property (state_r == ST_BREAK |-> !tx_out) // [R01]
        else $error("line not low during break");
    te_off_idle_a: assert property (clk_en_in && pick && !ctrl_r.te // [R11]
        |=> state_r == ST_IDLE && tx_out)
        else $error("disabled transmitter not idle at mark");
    one_pend_a: assert property (clk_en_in && start_brk && !sbk_rise // [R10]
        |=> !brk_pend_r)
        else $error("break request not consumed");
    char_start_a: assert property (clk_en_in && pick && ctrl_r.te && !idle_pend_r // [R11]
        && !brk_pend_r && !ctrl_r.send_break_request && data_full_r |=> state_r == ST_CHAR && !tx_out)
        else $error("character did not open with a start bit");

    brk_seen_c: cover property (start_brk ##1 state_r == ST_BREAK);
    lin_brk_c: cover property (start_brk && lin_master);
    idle_brk_c: cover property (state_r == ST_IDLE_LINE ##[1:400] state_r == ST_BREAK);
    char_sent_c: cover property (state_r == ST_CHAR ##1 state_r == ST_IDLE);
    frozen_brk_c: cover property (state_r == ST_BREAK && !clk_en_in);
endmodule // sci_break_generator

// [verification/serial_node_model.sv]
/*
 Remote serial node: measures each low run on the line in clock cycles
 and counts runs. Assumes one clock shared with the transmitter.
*/
`timescale 1ns/100ps
module serial_node_model (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic line_in,
    output logic [15:0] low_len_out,
    output logic [7:0] brk_cnt_out
);
    logic [15:0] run_r;
    // Length is known only at the rising edge, so a run is counted once
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            run_r <= 16'h0000;
            low_len_out <= 16'h0000;
            brk_cnt_out <= 8'h00;
        end else if (!line_in) begin
            run_r <= run_r + 16'h0001;
        end else if (run_r != 16'h0000) begin
            low_len_out <= run_r;
            brk_cnt_out <= brk_cnt_out + 8'h01;
            run_r <= 16'h0000;
        end
    end
endmodule // serial_node_model

// [verification/test_sci_break_generator.sv]
/*
 Self-checking bench for the break generator with a remote node model.
 Assumes brk_consts.svh on the include path.
*/
`timescale 1ns/100ps
`include "brk_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module test_sci_break_generator;
    logic clock_in, reset_in, clk_en_in, wr_in, rd_in, tx_out;
    logic [2:0] addr_in;
    logic [15:0] wdata_in, rdata_out, low_len, d;
    logic [7:0] brk_cnt, nb;
    logic lng, lin;
    int err_count = 0;
    int n_tests = 0;
    int seed = 53;
    int dv, ev, k, i;
    sci_break_generator DUT (.clock_in(clock_in), .reset_in(reset_in),
        .clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .tx_out(tx_out));
    serial_node_model node (.clock_in(clock_in), .reset_in(reset_in),
        .line_in(tx_out), .low_len_out(low_len), .brk_cnt_out(brk_cnt));
    function automatic int brk_cycles(logic l, logic n, int v);
        return (l ? 11 : (n ? 13 : 10)) * v;
    endfunction
    task automatic wr(input logic [2:0] a, input logic [15:0] w);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= w;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] r);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 r = rdata_out;
    endtask
    task automatic wait_brk(input logic [7:0] c);
        int j;
        for (j = 0; j < 3000 && brk_cnt !== c; j++) @(posedge clock_in);
        `CHK(brk_cnt, c)
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    // Far above the expected run length, so only a hang trips it
    initial begin
        #400000;
        err_count++;
        close_out();
    end
    initial begin
        reset_in = 1'b1;
        clk_en_in = 1'b1;
        addr_in = 3'h0;
        wdata_in = 16'h0000;
        wr_in = 1'b0;
        rd_in = 1'b0;
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        @(posedge clock_in);
        #1 `CHK(tx_out, 1'b1)
        rd(`OFF_BAUD_DIV, d);
        `CHK(d, `RST_BAUD_DIV)
        wr(3'h7, 16'hFFFF);
        rd(3'h7, d);
        `CHK(d, 16'h0000)
        wr(`OFF_CTRL_TWO, 16'h0001);
        nb = 8'h00;
        // First four passes walk every mode, the rest are random
        for (k = 0; k < 12; k++) begin
            // Divisor 0 must run as 1
            dv = (k == 1) ? 0 : ((k == 0) ? 1 : 1 + ($random(seed) & 3));
            ev = (dv == 0) ? 1 : dv;
            lng = (k < 4) ? k[0] : 1'($random(seed) & 1);
            lin = (k < 4) ? k[1] : 1'($random(seed) & 1);
            wr(`OFF_CTRL_ONE, {15'h0000, lng});
            wr(`OFF_CTRL_THREE, {15'h0000, lin});
            wr(`OFF_BAUD_DIV, dv[15:0]);
            wr(`OFF_CTRL_TWO, 16'h0003);
            wr(`OFF_CTRL_TWO, 16'h0001);
            nb++;
            wait_brk(nb);
            `CHK(low_len, 16'(brk_cycles(lng, lin, ev)))
            `CHK(lng || !lin || low_len >= 16'(13 * ev), 1'b1)
            repeat (30 * ev) @(posedge clock_in);
            `CHK(brk_cnt, nb)
            `CHK(tx_out, 1'b1)
        end
        wr(`OFF_CTRL_ONE, 16'h0000);
        wr(`OFF_CTRL_THREE, 16'h0000);
        wr(`OFF_BAUD_DIV, 16'h0002);
        wr(`OFF_CTRL_TWO, 16'h0003);
        repeat (45) @(posedge clock_in);
        wr(`OFF_CTRL_TWO, 16'h0001);
        nb++;
        wait_brk(nb);
        `CHK(low_len, 16'd60)
        repeat (40) @(posedge clock_in);
        wr(`OFF_CTRL_TWO, 16'h0000);
        wr(`OFF_CTRL_TWO, 16'h0001);
        wr(`OFF_CTRL_TWO, 16'h0003);
        wr(`OFF_CTRL_TWO, 16'h0001);
        for (i = 0; i < 500 && tx_out === 1'b1; i++) @(posedge clock_in);
        `CHK(i >= 10, 1'b1)
        nb++;
        wait_brk(nb);
        `CHK(low_len, 16'd20)
        // Frozen clock enable stretches the break by the frozen cycles
        wr(`OFF_BAUD_DIV, 16'h0001);
        wr(`OFF_CTRL_TWO, 16'h0003);
        wr(`OFF_CTRL_TWO, 16'h0001);
        clk_en_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        clk_en_in <= 1'b1;
        nb++;
        wait_brk(nb);
        `CHK(low_len, 16'd15)
        // Character: one start bit low, then mark
        wr(`OFF_TX_DATA, 16'h00FF);
        nb++;
        wait_brk(nb);
        `CHK(low_len, 16'd1)
        repeat (12) @(posedge clock_in);
        rd(`OFF_STATUS, d);
        `CHK(d, 16'h0001)
        close_out();
    end
endmodule // test_sci_break_generator
